//--- csil_pkg.sv
// Purpose: Shared constants and state types of the CAN status and
//    interrupt block.
// Assumes: One peripheral clock with a synchronous active high reset.
// Notes: Offsets are full byte addresses on the register bus.
package csil_pkg;

   localparam int NUM_MB = 8;
   localparam int TIMER_W = 16;
   localparam int TEC_W = 9;
   localparam int REC_W = 8;

   localparam logic [31:0] ADR_MODE = 32'hF800_0000;
   localparam logic [31:0] ADR_IRQ_SET = 32'hF800_0004;
   localparam logic [31:0] ADR_IRQ_CLR = 32'hF800_0008;
   localparam logic [31:0] ADR_IRQ_MASK = 32'hF800_000C;
   localparam logic [31:0] ADR_STATUS = 32'hF800_0010;
   localparam logic [31:0] ADR_TIMER = 32'hF800_0018;

   localparam int MODE_HOLD_BIT = 6;
   localparam int MODE_NO_RETRY_BIT = 7;

   localparam int SR_MB_LSB = 0;
   localparam int SR_ERR_ACTIVE = 16;
   localparam int SR_WARN = 17;
   localparam int SR_ERR_PASSIVE = 18;
   localparam int SR_BUS_OFF = 19;
   localparam int SR_SLEEP = 20;
   localparam int SR_WAKEUP = 21;
   localparam int SR_ROLLOVER = 22;
   localparam int SR_TSTAMP = 23;
   localparam int SR_CRC_ERR = 24;
   localparam int SR_STUFF_ERR = 25;
   localparam int SR_ACK_ERR = 26;
   localparam int SR_FORM_ERR = 27;
   localparam int SR_BIT_ERR = 28;
   localparam int SR_RX_ACTIVE = 29;
   localparam int SR_TX_ACTIVE = 30;
   localparam int SR_OVL_ACTIVE = 31;

   localparam logic [31:0] MASK_IMPL = 32'h1FFF_00FF;
   localparam logic [31:0] MASK_RST = 32'h0000_0000;
   localparam logic [31:0] STICKY_RST = 32'h0000_0000;
   localparam logic [NUM_MB-1:0] MB_RST = 8'h00;
   localparam logic [TIMER_W-1:0] TIMER_MAX = 16'hFFFF;
   localparam logic [TIMER_W-1:0] TIMER_RST = 16'h0000;

   localparam logic [9:0] WARN_LIMIT = 10'd96;
   localparam logic [9:0] PASSIVE_LIMIT = 10'd128;
   localparam logic [9:0] BUS_OFF_LIMIT = 10'd256;

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [31:0] mask;
      logic [31:0] sticky;
      logic no_retry;
      logic hold;
      logic [NUM_MB-1:0] pend;
      logic [NUM_MB-1:0] rdy;
      logic [NUM_MB-1:0] abt;
      logic irq;
   } csil_state_t;

   typedef struct packed {
      logic [TIMER_W-1:0] value;
      logic roll;
   } csil_timer_state_t;

endpackage

//--- csil_timer.sv
// Purpose: Free running internal timer with optional hold at maximum.
// Assumes: Tick and clear come from logic on the same clock.
// Notes: The rollover pulse follows the tick that meets the maximum.
`timescale 1ns/1ps
module csil_timer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire logic clear_i,
   input wire logic hold_at_max_i,
   output logic [csil_pkg::TIMER_W-1:0] value_o,
   output logic rollover_o
);
   import csil_pkg::*;

   csil_timer_state_t st_reg;
   csil_timer_state_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.roll = 1'b0;
      if (clear_i) begin
         st_next.value = TIMER_RST;
      end else if (tick_i) begin
         if (st_reg.value == TIMER_MAX) begin
            // Held value stays put until a clear, or a tick after the hold is dropped.
            if (!hold_at_max_i) begin
               st_next.value = TIMER_RST;
            end
            // Both the wrap and the freeze report a rollover.
            st_next.roll = 1'b1;
         end else begin
            st_next.value = st_reg.value + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '{value: TIMER_RST, roll: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign value_o = st_reg.value;
   assign rollover_o = st_reg.roll;

endmodule

//--- csil_top.sv
// Purpose: Status flags, interrupt masks, timer and retry options of a
//    CAN controller, reached over a classic Wishbone slave.
// Assumes: All event and level inputs come from logic on clk_i.
// Notes: Every access is answered one cycle after it is seen.
//
// Behaviour
// - Without hold, timer wraps past maximum.
// - With hold, timer stops at maximum.
// - Without no-retry, lost arbitration keeps request.
// - With no-retry, loss aborts, raising abort, ready.
// - Enable-set ones set mask bits.
// - Enable-clear ones clear mask bits.
// - Mask register reads current enables.
// - Mailboxes bits 0-7, states bits 16-23.
// - Bus error sources occupy bits 24-28.
// - Mailbox bit reads ready or abort.
// - Confinement flags sticky until status read.
// - Error active when neither passive nor off.
// - Warning when either counter reaches 96.
// - Passive when either counter reaches 128.
// - Bus off when transmit counter reaches 256.
// - Frozen timer at maximum raises rollover flag.
`timescale 1ns/1ps
module csil_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic timer_tick_i,
   input wire logic timer_reset_i,
   output logic [csil_pkg::TIMER_W-1:0] timer_value_o,
   input wire logic frame_time_capture_i,
   input wire logic crc_error_i,
   input wire logic stuff_error_i,
   input wire logic ack_error_i,
   input wire logic form_error_i,
   input wire logic bit_error_i,
   input wire logic sleep_i,
   input wire logic wakeup_i,
   input wire logic overload_tx_active_i,
   input wire logic tx_active_i,
   input wire logic rx_active_i,
   input wire logic [csil_pkg::TEC_W-1:0] transmit_error_count_i,
   input wire logic [csil_pkg::REC_W-1:0] receive_error_count_i,
   input wire logic [csil_pkg::NUM_MB-1:0] mb_tx_request_i,
   input wire logic [csil_pkg::NUM_MB-1:0] mb_arb_loss_i,
   input wire logic [csil_pkg::NUM_MB-1:0] mb_done_i,
   input wire logic [csil_pkg::NUM_MB-1:0] mb_flag_clear_i,
   output logic [csil_pkg::NUM_MB-1:0] mb_pending_o,
   output logic [csil_pkg::NUM_MB-1:0] mailbox_ready_flag_o,
   output logic [csil_pkg::NUM_MB-1:0] mailbox_abort_flag_o,
   output logic irq_o
);
   import csil_pkg::*;

   csil_state_t st_reg;
   csil_state_t st_next;

   logic [TIMER_W-1:0] timer_value;
   logic timer_roll;
   logic req;
   logic rd_status;
   logic [31:0] wr_bits;
   logic [31:0] status_now;
   logic [31:0] status_after;
   logic [31:0] sticky_set;
   logic [9:0] tec_ext;
   logic [9:0] rec_ext;
   logic passive;
   logic bus_off;
   logic warn;
   logic [4:0] live_lvl;

   function automatic logic hit(input logic [31:0] adr,
                                input logic [31:0] target);
      hit = (adr == target);
   endfunction

   function automatic logic [31:0] lanes(input logic [3:0] sel);
      lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   // Combines sticky flags, mailbox flags and live levels into one word.
   // Live levels come in as an argument, because a continuous assignment
   // would not wake up on a signal that the function only reads inside.
   function automatic logic [31:0] build_status(
      input logic [31:0] sticky,
      input logic [NUM_MB-1:0] rdy,
      input logic [NUM_MB-1:0] abt,
      input logic [4:0] live
   );
      logic [31:0] s;
      s = sticky & MASK_IMPL;
      s[SR_MB_LSB +: NUM_MB] = rdy | abt;
      s[SR_SLEEP] = live[0];
      s[SR_WAKEUP] = live[1];
      s[SR_RX_ACTIVE] = live[2];
      s[SR_TX_ACTIVE] = live[3];
      s[SR_OVL_ACTIVE] = live[4];
      build_status = s;
   endfunction

   csil_timer u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(timer_tick_i),
      .clear_i(timer_reset_i),
      .hold_at_max_i(st_reg.hold),
      .value_o(timer_value),
      .rollover_o(timer_roll)
   );

   assign tec_ext = {1'b0, transmit_error_count_i};
   assign rec_ext = {2'b00, receive_error_count_i};
   assign passive = (tec_ext >= PASSIVE_LIMIT) ||
                    (rec_ext >= PASSIVE_LIMIT);
   assign bus_off = (tec_ext >= BUS_OFF_LIMIT);
   assign warn = (tec_ext >= WARN_LIMIT) ||
                 (rec_ext >= WARN_LIMIT);

   assign req = wb_cyc_i && wb_stb_i && !st_reg.ack;
   assign rd_status = req && !wb_we_i && hit(wb_adr_i, ADR_STATUS);
   assign wr_bits = wb_dat_i & lanes(wb_sel_i);
   assign live_lvl = {overload_tx_active_i, tx_active_i, rx_active_i,
                      wakeup_i, sleep_i};
   assign status_now = build_status(st_reg.sticky, st_reg.rdy,
                                    st_reg.abt, live_lvl);

   always_comb begin
      sticky_set = '0;
      sticky_set[SR_ERR_ACTIVE] = !passive && !bus_off;
      sticky_set[SR_WARN] = warn;
      sticky_set[SR_ERR_PASSIVE] = passive;
      sticky_set[SR_BUS_OFF] = bus_off;
      sticky_set[SR_ROLLOVER] = timer_roll;
      sticky_set[SR_TSTAMP] = frame_time_capture_i;
      sticky_set[SR_CRC_ERR] = crc_error_i;
      sticky_set[SR_STUFF_ERR] = stuff_error_i;
      sticky_set[SR_ACK_ERR] = ack_error_i;
      sticky_set[SR_FORM_ERR] = form_error_i;
      sticky_set[SR_BIT_ERR] = bit_error_i;
   end

   always_comb begin
      st_next = st_reg;
      st_next.ack = req;
      if (req) begin
         st_next.rdata = 32'h0000_0000;
      end

      if (req && !wb_we_i) begin
         if (hit(wb_adr_i, ADR_MODE)) begin
            st_next.rdata[MODE_HOLD_BIT] = st_reg.hold;
            st_next.rdata[MODE_NO_RETRY_BIT] = st_reg.no_retry;
         end else if (hit(wb_adr_i, ADR_IRQ_MASK)) begin
            st_next.rdata = st_reg.mask;
         end else if (hit(wb_adr_i, ADR_STATUS)) begin
            st_next.rdata = status_now;
         end else if (hit(wb_adr_i, ADR_TIMER)) begin
            st_next.rdata[TIMER_W-1:0] = timer_value;
         end
      end

      if (req && wb_we_i) begin
         if (hit(wb_adr_i, ADR_MODE) && wb_sel_i[0]) begin
            st_next.hold = wb_dat_i[MODE_HOLD_BIT];
            st_next.no_retry = wb_dat_i[MODE_NO_RETRY_BIT];
         end else if (hit(wb_adr_i, ADR_IRQ_SET)) begin
            st_next.mask = st_reg.mask | (wr_bits & MASK_IMPL);
         end else if (hit(wb_adr_i, ADR_IRQ_CLR)) begin
            st_next.mask = st_reg.mask & ~wr_bits;
         end
      end

      // A status read clears the sticky flags, but an event in the same
      // cycle still lands, so nothing is lost between read and clear.
      if (rd_status) begin
         st_next.sticky = STICKY_RST;
      end
      st_next.sticky = (st_next.sticky | sticky_set) & MASK_IMPL;

      for (int i = 0; i < NUM_MB; i++) begin
         if (mb_flag_clear_i[i] || mb_tx_request_i[i]) begin
            st_next.rdy[i] = 1'b0;
            st_next.abt[i] = 1'b0;
         end
         if (mb_tx_request_i[i]) begin
            st_next.pend[i] = 1'b1;
         end
         if (mb_done_i[i]) begin
            st_next.pend[i] = 1'b0;
            st_next.rdy[i] = 1'b1;
         end
         if (mb_arb_loss_i[i] && st_reg.pend[i]) begin
            if (st_reg.no_retry) begin
               st_next.pend[i] = 1'b0;
               st_next.rdy[i] = 1'b1;
               st_next.abt[i] = 1'b1;
            end else begin
               st_next.pend[i] = 1'b1;
            end
         end
      end
   end

   assign status_after = build_status(st_next.sticky, st_next.rdy,
                                      st_next.abt, live_lvl);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg.ack <= 1'b0;
         st_reg.rdata <= 32'h0000_0000;
         st_reg.mask <= MASK_RST;
         st_reg.sticky <= STICKY_RST;
         st_reg.no_retry <= 1'b0;
         st_reg.hold <= 1'b0;
         st_reg.pend <= MB_RST;
         st_reg.rdy <= MB_RST;
         st_reg.abt <= MB_RST;
         st_reg.irq <= 1'b0;
      end else begin
         st_reg <= st_next;
         // Registered so the line never glitches on level inputs.
         st_reg.irq <= |(status_after & st_next.mask);
      end
   end

   assign wb_ack_o = st_reg.ack;
   assign wb_dat_o = st_reg.rdata;
   assign timer_value_o = timer_value;
   assign mb_pending_o = st_reg.pend;
   assign mailbox_ready_flag_o = st_reg.rdy;
   assign mailbox_abort_flag_o = st_reg.abt;
   assign irq_o = st_reg.irq;

endmodule

//--- csil_properties.sv
// Purpose: Port level checks of the CAN status and interrupt block.
// Assumes: One clock; checks rest while rst_i is high.
// Notes: Sticky flags are judged from inputs two edges back.
`timescale 1ns/1ps
module csil_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic timer_tick_i,
   input wire logic timer_reset_i,
   input wire logic [csil_pkg::TIMER_W-1:0] timer_value_o,
   input wire logic overload_tx_active_i,
   input wire logic tx_active_i,
   input wire logic rx_active_i,
   input wire logic [csil_pkg::TEC_W-1:0] transmit_error_count_i,
   input wire logic [csil_pkg::REC_W-1:0] receive_error_count_i,
   input wire logic [csil_pkg::NUM_MB-1:0] mb_arb_loss_i,
   input wire logic [csil_pkg::NUM_MB-1:0] mailbox_ready_flag_o,
   input wire logic [csil_pkg::NUM_MB-1:0] mailbox_abort_flag_o
);
   import csil_pkg::*;
   logic rd_sr;
   logic [3:0] conf;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   assign rd_sr = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o &&
      wb_adr_i == ADR_STATUS;
   // Bus off, passive, warning and active, as the counters stand now.
   assign conf[3] = transmit_error_count_i >= 9'h100;
   assign conf[2] = transmit_error_count_i >= 9'h080 ||
      receive_error_count_i >= 8'h80;
   assign conf[1] = transmit_error_count_i >= 9'h060 ||
      receive_error_count_i >= 8'h60;
   assign conf[0] = !conf[2] && !conf[3];
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack stood longer than one cycle");
   property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer)
      else $error("access not answered in one cycle");
   property p_timer_step; timer_tick_i && !timer_reset_i &&
      timer_value_o != 16'hFFFF |=> timer_value_o ==
      $past(timer_value_o) + 16'h0001; endproperty
   a_timer_step: assert property (p_timer_step)
      else $error("timer did not advance by one");
   property p_timer_clr; timer_reset_i |=> timer_value_o == 16'h0000;
   endproperty
   a_timer_clr: assert property (p_timer_clr)
      else $error("timer reset did not restart the count");
   property p_abort_cause; (mailbox_abort_flag_o &
      ~$past(mailbox_abort_flag_o) & ~$past(mb_arb_loss_i)) == 8'h00;
   endproperty
   a_abort_cause: assert property (p_abort_cause)
      else $error("abort flag rose without a lost arbitration");
   property p_abort_rdy; (mailbox_abort_flag_o & ~mailbox_ready_flag_o)
      == 8'h00; endproperty
   a_abort_rdy: assert property (p_abort_rdy)
      else $error("abort flag without ready flag");
   property p_mb_status; rd_sr |=> wb_ack_o && wb_dat_o[7:0] ==
      $past(mailbox_ready_flag_o | mailbox_abort_flag_o); endproperty
   a_mb_status: assert property (p_mb_status)
      else $error("mailbox status bits wrong");
   property p_busy; rd_sr |=> wb_dat_o[31:29] ==
      $past({overload_tx_active_i, tx_active_i, rx_active_i}); endproperty
   a_busy: assert property (p_busy)
      else $error("busy bits wrong");
   property p_conf; rd_sr |=> (wb_dat_o[19:16] & $past(conf, 2)) ==
      $past(conf, 2); endproperty
   a_conf: assert property (p_conf)
      else $error("confinement flag missing");
   c_status: cover property (rd_sr);
   c_abort: cover property (|mailbox_abort_flag_o);
   c_top: cover property (timer_value_o == 16'hFFFF);
endmodule
bind csil_top csil_chk csil_chk_inst (.*);

//--- csil_arb_model.sv
// Purpose: Stand-in for the other nodes contending for the CAN bus.
// Assumes: Pending mailboxes come straight from the block.
// Notes: Only the lowest pending mailbox is ever put on the bus.
`timescale 1ns/1ps
module csil_arb_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] pending_i,
   input wire logic lose_i,
   input wire logic win_i,
   output logic [7:0] arb_loss_o,
   output logic [7:0] done_o
);
   logic [7:0] lead;
   assign lead = pending_i & (~pending_i + 8'h01);
   always_ff @(posedge clk_i) begin
      arb_loss_o <= (rst_i || !lose_i) ? 8'h00 : lead;
      done_o <= (rst_i || !win_i) ? 8'h00 : lead;
   end
endmodule

//--- tb_top.sv
// Purpose: Self-checking bench of the CAN status and interrupt block.
// Assumes: Wishbone answers within a few cycles.
// Notes: The timer test alone takes some 65536 cycles.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
   mismatches++; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
   import csil_pkg::*;
   typedef struct packed {
      logic [8:0] transmit_error_count;
      logic [7:0] receive_error_count;
      logic [3:0] conf;
   } csil_row_t;
   csil_row_t rows [10] = '{'{9'h000, 8'h00, 4'h1}, '{9'h05F, 8'h5F, 4'h1},
      '{9'h060, 8'h00, 4'h3}, '{9'h000, 8'h60, 4'h3}, '{9'h07F, 8'h7F, 4'h3},
      '{9'h080, 8'h00, 4'h6}, '{9'h000, 8'h80, 4'h6}, '{9'h0FF, 8'h00, 4'h6},
      '{9'h100, 8'h00, 4'hE}, '{9'h1FF, 8'hFF, 4'hE}};
   logic clk_i = 1'b0, rst_i = 1'b1, lose = 1'b0, win = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, d;
   logic [3:0] wb_sel_i = 4'h0;
   logic timer_tick_i = 1'b0, timer_reset_i = 1'b0, irq_o;
   logic [15:0] timer_value_o;
   logic [5:0] ev = 6'h00;
   logic [4:0] lv = 5'h00;
   logic [8:0] transmit_error_count_i = 9'h000;
   logic [7:0] receive_error_count_i = 8'h00, mb_tx_request_i = 8'h00;
   logic [7:0] mb_flag_clear_i = 8'h00, mb_pending_o;
   logic [7:0] mailbox_ready_flag_o, mailbox_abort_flag_o;
   wire [7:0] mb_arb_loss_i, mb_done_i;
   wire crc_error_i = ev[0], stuff_error_i = ev[1], ack_error_i = ev[2];
   wire form_error_i = ev[3], bit_error_i = ev[4];
   wire frame_time_capture_i = ev[5], sleep_i = lv[0], wakeup_i = lv[1];
   wire rx_active_i = lv[2], tx_active_i = lv[3];
   wire overload_tx_active_i = lv[4];
   int n_checks = 0, mismatches = 0, cycles = 0;
   csil_top csil_top_inst (.*);
   csil_arb_model csil_arb_model_inst (.clk_i(clk_i), .rst_i(rst_i),
      .pending_i(mb_pending_o), .lose_i(lose), .win_i(win),
      .arb_loss_o(mb_arb_loss_i), .done_o(mb_done_i));
   always #50 clk_i = ~clk_i;
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 90000) begin
         mismatches++;
         final_report();
      end
   end
   task automatic wb(input logic we, input logic [31:0] adr, dat,
      input logic [3:0] sel);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
      {wb_adr_i, wb_dat_i, wb_sel_i} <= {adr, dat, sel};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      d = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   task automatic step(input logic [5:0] v, input logic l, w,
      input logic [7:0] r);
      @(posedge clk_i);
      {ev, lose, win, mb_tx_request_i} <= {v, l, w, r};
      @(posedge clk_i);
      {ev, lose, win, mb_tx_request_i} <= 16'h0000;
      repeat (2) @(posedge clk_i);
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      foreach (rows[i]) begin
         transmit_error_count_i <= rows[i].transmit_error_count;
         receive_error_count_i <= rows[i].receive_error_count;
         repeat (2) @(posedge clk_i);
         wb(1'b0, ADR_STATUS, 32'h0, 4'hF);
         wb(1'b0, ADR_STATUS, 32'h0, 4'hF);
         `CHK(d[19:18], rows[i].conf[3:2])
         `CHK(d[17:16], rows[i].conf[1:0])
      end
      {transmit_error_count_i, receive_error_count_i} <= 17'h00000;
      wb(1'b1, ADR_IRQ_SET, 32'hFFFF_FFFF, 4'h0);
      wb(1'b0, ADR_IRQ_MASK, 32'h0, 4'hF);
      `CHK(d, 32'h0000_0000)
      wb(1'b1, ADR_IRQ_SET, 32'hFFFF_FFFF, 4'hF);
      wb(1'b0, ADR_IRQ_MASK, 32'h0, 4'hF);
      `CHK(d, 32'h1FFF_00FF)
      wb(1'b1, ADR_IRQ_CLR, 32'h0100_00F0, 4'hF);
      wb(1'b1, ADR_IRQ_SET, 32'h0000_0000, 4'hF);
      wb(1'b0, ADR_IRQ_MASK, 32'h0, 4'hF);
      `CHK(d, 32'h1EFF_000F)
      `CHK(irq_o, 1'b1)
      wb(1'b0, 32'hF800_0100, 32'h0, 4'hF);
      `CHK(d, 32'h0)
      wb(1'b1, ADR_IRQ_CLR, 32'hFEFF_FFFF, 4'hF);
      wb(1'b1, ADR_IRQ_SET, 32'h0100_0000, 4'hF);
      wb(1'b0, ADR_STATUS, 32'h0, 4'hF);
      @(posedge clk_i);
      `CHK(irq_o, 1'b0)
      step(6'h01, 1'b0, 1'b0, 8'h00);
      `CHK(irq_o, 1'b1)
      wb(1'b0, ADR_STATUS, 32'h0, 4'hF);
      for (int i = 0; i < 6; i++) begin
         step(6'h01 << i, 1'b0, 1'b0, 8'h00);
         wb(1'b0, ADR_STATUS, 32'h0, 4'hF);
         `CHK(d[28:23], 6'h01 << ((i + 1) % 6))
      end
      lv <= 5'h15;
      wb(1'b0, ADR_STATUS, 32'h0, 4'hF);
      `CHK({d[31:29], d[21:20]}, 5'h15)
      lv <= 5'h00;
      // Mailbox 2 loses arbitration once with retry, once without.
      step(6'h00, 1'b0, 1'b0, 8'h04);
      step(6'h00, 1'b1, 1'b0, 8'h00);
      `CHK(mb_pending_o, 8'h04)
      `CHK(mailbox_abort_flag_o, 8'h00)
      wb(1'b1, ADR_MODE, 32'h0000_0080, 4'h1);
      step(6'h00, 1'b1, 1'b0, 8'h00);
      `CHK(mb_pending_o, 8'h00)
      `CHK(mailbox_abort_flag_o, 8'h04)
      step(6'h00, 1'b0, 1'b0, 8'h02);
      step(6'h00, 1'b0, 1'b1, 8'h00);
      `CHK(mailbox_ready_flag_o, 8'h06)
      wb(1'b0, ADR_STATUS, 32'h0, 4'hF);
      `CHK(d[7:0], 8'h06)
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      `CHK(irq_o, 1'b0)
      `CHK(mb_pending_o | mailbox_ready_flag_o, 8'h00)
      wb(1'b0, ADR_MODE, 32'h0, 4'hF);
      `CHK(d, 32'h0000_0000)
      wb(1'b0, ADR_IRQ_MASK, 32'h0, 4'hF);
      `CHK(d, 32'h0000_0000)
      // Hold at the top first, then drop the hold and wrap once.
      wb(1'b1, ADR_MODE, 32'h0000_0040, 4'h1);
      timer_tick_i <= 1'b1;
      repeat (65540) @(posedge clk_i);
      timer_tick_i <= 1'b0;
      @(posedge clk_i);
      `CHK(timer_value_o, 16'hFFFF)
      wb(1'b0, ADR_STATUS, 32'h0, 4'hF);
      `CHK(d[22], 1'b1)
      wb(1'b1, ADR_MODE, 32'h0000_0000, 4'h1);
      timer_tick_i <= 1'b1;
      @(posedge clk_i);
      timer_tick_i <= 1'b0;
      @(posedge clk_i);
      `CHK(timer_value_o, 16'h0000)
      timer_tick_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      timer_tick_i <= 1'b0;
      wb(1'b0, ADR_TIMER, 32'h0, 4'hF);
      `CHK(d, 32'h0000_0003)
      timer_reset_i <= 1'b1;
      @(posedge clk_i);
      timer_reset_i <= 1'b0;
      @(posedge clk_i);
      `CHK(timer_value_o, 16'h0000)
      final_report();
   end
endmodule
